/* File: verification/cable_peer.sv */
// Peer model: a master module on the sync cable, seen from a slave
// Assumes the bench raises run_in to start the master and drops it to stop
module cable_peer
   import trig_sync_pkg::*;
(
   input  wire logic run_in,
   output sync_link_t link_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Cable clock stands still outside a run, at a rate of its own
   initial begin
      link_out = '0;
      forever begin
         wait (run_in);
         link_out.sync_trig = 1'b1;
         while (run_in) begin
            #13 link_out.sync_clk = ~link_out.sync_clk;
         end
         link_out = '0;
      end
   end
endmodule

/* File: verification/trig_sync_test.sv */
// Testbench: register port, trigger sources and cable sync of trig_sync
// Assumes a short stop wait of 20 cycles and a peer master on the cable
module trig_sync_test
   import trig_sync_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in, rst_in, wr_in, rd_in, ext_trig_in, peer_run, rd_d;
   logic [3:0]  addr_in;
   logic [31:0] wdata_in, rdata_out;
   logic [6:0]  ch0_level_in, thr;
   logic [16:0] seed;
   logic        clk_seen;
   sync_link_t  link_in, link_out;
   logic        link_oe_out, sample_tick_out, running_out;
   logic [31:0] exp_q[$];
   int          num_errors, cmp_count;

   trig_sync #(.STOP_WAIT(20)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
      .ce_in(1'b1), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata_out), .ext_trig_in(ext_trig_in),
      .ch0_level_in(ch0_level_in), .link_in(link_in), .link_out(link_out),
      .link_oe_out(link_oe_out), .sample_tick_out(sample_tick_out),
      .running_out(running_out));
   cable_peer u_peer (.run_in(peer_run), .link_out(link_in));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [16:0] lfsr(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (num_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // A gap edge after each strobe keeps one assignment per time step
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      addr_in <= a;
      rd_in <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic bit_at(input int n, ref logic s, input logic v);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
      chk({31'h0, s}, {31'h0, v});
      @(posedge clk_in);
   endtask
   task automatic wait_run(input logic v, input int n);
      for (int i = 0; i < n && running_out !== v; i++) @(negedge clk_in);
      chk({31'h0, running_out}, {31'h0, v});
      @(posedge clk_in);
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) rd_d <= rd_in;
   always @(negedge clk_in) if (rd_d) begin
      chk(rdata_out, exp_q.pop_front());
   end
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      #400000;
      num_errors++;
      close_out();
   end

   initial begin
      {rst_in, wr_in, rd_in, ext_trig_in, peer_run} = 5'h10;
      {addr_in, wdata_in, ch0_level_in} = '0;
      {num_errors, cmp_count} = '0;
      seed = 17'd85275;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_THRESH, {25'h0, THRESH_RESET});
      rd(OFS_DIV, {16'h0, DIV_RESET});
      rd(4'hF, 32'h0);
      wr(OFS_CMD, 32'h1);
      wr(OFS_CMD, 32'h4);
      wait_run(1'b1, 8);
      rd(OFS_STATUS, 32'h3);
      wr(OFS_CMD, 32'h2);
      wait_run(1'b0, 40);
      wr(OFS_CTRL, 32'h1);
      wr(OFS_CMD, 32'h1);
      ext_trig_in <= 1'b1;
      wait_run(1'b1, 8);
      ext_trig_in <= 1'b0;
      wr(OFS_CMD, 32'h2);
      wait_run(1'b0, 40);
      // Random level; equal to the threshold must not fire, one step over must
      seed = lfsr(seed);
      thr = 7'h02 + 7'(seed % 97);
      wr(OFS_THRESH, {25'h0, thr});
      ch0_level_in <= thr;
      rd(OFS_THRESH, {25'h0, thr});
      wr(OFS_CTRL, 32'h2);
      wr(OFS_CMD, 32'h1);
      bit_at(6, running_out, 1'b0);
      ch0_level_in <= thr + 7'h01;
      wait_run(1'b1, 8);
      wr(OFS_CMD, 32'h2);
      wait_run(1'b0, 40);
      ch0_level_in <= 7'h00;
      wr(OFS_THRESH, 32'h7F);
      rd(OFS_THRESH, {25'h0, THRESH_MAX});
      wr(OFS_CTRL, 32'h4);
      bit_at(0, link_oe_out, 1'b1);
      wr(OFS_CMD, 32'h1);
      wr(OFS_CMD, 32'h4);
      wait_run(1'b1, 8);
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk({31'h0, link_out.sync_trig}, 32'h1);
      chk({31'h0, sample_tick_out}, 32'h1);
      clk_seen = link_out.sync_clk;
      @(negedge clk_in);
      chk({31'h0, link_out.sync_clk}, {31'h0, ~clk_seen});
      @(posedge clk_in);
      wr(OFS_CMD, 32'h2);
      wait_run(1'b0, 40);
      rd(OFS_CTRL, 32'h4);
      wr(OFS_CTRL, 32'h9);
      bit_at(0, link_oe_out, 1'b0);
      wr(OFS_CMD, 32'h1);
      ext_trig_in <= 1'b1;
      bit_at(10, running_out, 1'b0);
      ext_trig_in <= 1'b0;
      rd(OFS_STATUS, 32'h1);
      peer_run <= 1'b1;
      wait_run(1'b1, 16);
      peer_run <= 1'b0;
      bit_at(20, running_out, 1'b1);
      wr(OFS_CMD, 32'h2);
      wait_run(1'b0, 40);
      wr(OFS_CMD, 32'h1);
      wr(OFS_CMD, 32'h2);
      rd(OFS_STATUS, 32'h2);
      repeat (30) @(posedge clk_in);
      rd(OFS_STATUS, 32'h0);
      wr(OFS_CTRL, 32'h0);
      rd(OFS_CTRL, 32'h0);
      close_out();
   end
endmodule

/* File: verilog/trig_sync.sv */
// Output trigger selection and master/slave module synchronisation
// Assumes all inputs synchronous to clk_in except the sync cable and trigger pin
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module trig_sync
   import trig_sync_pkg::*;
#(
   parameter longint STOP_WAIT = STOP_WAIT_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic [3:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   input  wire logic        ext_trig_in,
   input  wire logic [6:0]  ch0_level_in,
   input  sync_link_t       link_in,
   output sync_link_t       link_out,
   output logic             link_oe_out,
   output logic             sample_tick_out,
   output logic             running_out
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      src_t        src;
      sync_t       sync;
      logic [6:0]  thresh;
      logic [15:0] div;
      logic [15:0] div_cnt;
      logic        tick;
      logic        mclk;
      state_t      st;
      logic        ext_m;
      logic        ext_s;
      logic        ext_d;
      logic        lt_m;
      logic        lt_s;
      logic        lc_m;
      logic        lc_s;
      logic        lc_d;
      logic        above;
      logic        trig_out;
      logic [39:0] wait_cnt;
      logic [31:0] rdata;
   } state_reg_t;

   state_reg_t s_reg;
   state_reg_t s_next;

   logic       wr_ctrl;
   logic       wr_cmd;
   logic       ext_rise;
   logic       thr_rise;
   logic       fire;
   logic       local_tick;
   logic [15:0] div_sel;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      wr_ctrl = wr_in && addr_in == OFS_CTRL;
      wr_cmd  = wr_in && addr_in == OFS_CMD;
      ext_rise  = s_reg.ext_s && !s_reg.ext_d;
      thr_rise  = 1'b0;
      // Slaves tick on each rising edge of the master's cable clock, once per two master ticks
      local_tick = (s_reg.sync == SYNC_SLAVE) ?
                   (s_reg.lc_s && !s_reg.lc_d) : s_reg.tick;
      div_sel = (s_reg.div == 16'h0000) ? 16'h0001 : s_reg.div;
      s_next = s_reg;

      // Threshold comparator with hysteresis below the threshold
      if (!s_reg.above && ch0_level_in > s_reg.thresh) begin
         s_next.above = 1'b1;
         thr_rise = 1'b1;
      end else if (s_reg.above &&
                   {1'b0, ch0_level_in} + {1'b0, HYST_STEPS} <=
                   {1'b0, s_reg.thresh}) begin
         // Widened so a full-scale level cannot wrap and drop the flag
         s_next.above = 1'b0;
      end

      // Only the first qualifying event after arming is taken
      fire = 1'b0;
      if (s_reg.st == ST_ARMED) begin
         case (s_reg.sync)
            SYNC_SLAVE: fire = s_reg.lt_s;
            default: begin
               case (s_reg.src)
                  SRC_EXT:   fire = ext_rise;
                  SRC_THRES: fire = thr_rise;
                  default:   fire = 1'b0;
               endcase
            end
         endcase
         if (wr_cmd && wdata_in[CMD_START_BIT] &&
             s_reg.sync != SYNC_SLAVE && s_reg.src == SRC_SOFT)
            fire = 1'b1;
      end

      // Input synchronisers: first stage feeds only the second
      s_next.ext_m = ext_trig_in;
      s_next.ext_s = s_reg.ext_m;
      s_next.ext_d = s_reg.ext_s;
      s_next.lt_m  = link_in.sync_trig;
      s_next.lt_s  = s_reg.lt_m;
      s_next.lc_m  = link_in.sync_clk;
      s_next.lc_s  = s_reg.lc_m;
      s_next.lc_d  = s_reg.lc_s;

      // One internal clock from the module clock paces the cable clock out and, outside slave mode, the local tick
      s_next.tick = 1'b0;
      if (s_reg.div_cnt + 16'h0001 >= div_sel) begin
         s_next.div_cnt = 16'h0000;
         s_next.tick = 1'b1;
         s_next.mclk = ~s_reg.mclk;
      end else begin
         s_next.div_cnt = s_reg.div_cnt + 16'h0001;
      end

      if (wr_ctrl) begin
         s_next.src  = src_t'(wdata_in[CTRL_SRC_LSB +: 2]);
         s_next.sync = sync_t'(wdata_in[CTRL_SYNC_LSB +: 2]);
      end
      if (wr_in && addr_in == OFS_THRESH) begin
         if (wdata_in[6:0] < THRESH_MIN)
            s_next.thresh = THRESH_MIN;
         else if (wdata_in[6:0] > THRESH_MAX)
            s_next.thresh = THRESH_MAX;
         else
            s_next.thresh = wdata_in[6:0];
      end
      if (wr_in && addr_in == OFS_DIV)
         s_next.div = wdata_in[15:0];

      case (s_reg.st)
         ST_IDLE: begin
            if (wr_cmd && wdata_in[CMD_ARM_BIT])
               s_next.st = ST_ARMED;
         end
         ST_ARMED: begin
            if (fire) begin
               s_next.st = ST_RUN;
            end else if (wr_cmd && wdata_in[CMD_STOP_BIT]) begin
               if (s_reg.sync == SYNC_SLAVE) begin
                  s_next.st = ST_STOP;
                  s_next.wait_cnt = 40'(STOP_WAIT);
               end else begin
                  s_next.st = ST_IDLE;
               end
            end
         end
         ST_RUN: begin
            // Master trigger dropping does not end a slave run
            if (wr_cmd && wdata_in[CMD_STOP_BIT])
               s_next.st = ST_IDLE;
         end
         ST_STOP: begin
            if (s_reg.wait_cnt <= 40'h0000000001)
               s_next.st = ST_IDLE;
            else
               s_next.wait_cnt = s_reg.wait_cnt - 40'h0000000001;
         end
         default: s_next.st = ST_IDLE;
      endcase

      // Master holds its cable trigger high while running
      s_next.trig_out = (s_next.st == ST_RUN) &&
                        s_next.sync == SYNC_MASTER;
      if (s_next.sync != SYNC_MASTER)
         s_next.trig_out = 1'b0;

      s_next.rdata = 32'h00000000;
      if (rd_in) begin
         case (addr_in)
            OFS_CTRL:   s_next.rdata = {28'h0000000, s_reg.sync, s_reg.src};
            OFS_THRESH: s_next.rdata = {25'h0000000, s_reg.thresh};
            OFS_STATUS: s_next.rdata = {29'h00000000, s_reg.above,
                                        s_reg.st};
            OFS_DIV:    s_next.rdata = {16'h0000, s_reg.div};
            default:    s_next.rdata = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_reg          <= '0;
         s_reg.src      <= SRC_SOFT;
         s_reg.sync     <= SYNC_NONE;
         s_reg.thresh   <= THRESH_RESET;
         s_reg.div      <= DIV_RESET;
         s_reg.st       <= ST_IDLE;
      end else if (ce_in) begin
         s_reg <= s_next;
      end
   end

   // Cable driven only as master; within one period of the local start
   assign link_oe_out        = s_reg.sync == SYNC_MASTER;
   assign link_out.sync_trig = s_reg.trig_out;
   assign link_out.sync_clk  = s_reg.mclk;
   assign sample_tick_out    = local_tick && s_reg.st == ST_RUN;
   assign running_out        = s_reg.st == ST_RUN;
   assign rdata_out          = s_reg.rdata;

   ////////////////////////////////////////////////////////////////////////
   soft_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && s_reg.st == ST_ARMED && s_reg.sync == SYNC_NONE &&
      s_reg.src == SRC_SOFT && wr_cmd && wdata_in[CMD_START_BIT]
      |=> running_out)
      else $error("software start did not start output");
   ext_edge_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && s_reg.st == ST_ARMED && s_reg.sync != SYNC_SLAVE &&
      s_reg.src == SRC_EXT && ext_rise |=> running_out)
      else $error("external edge missed");
   thr_fire_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && s_reg.st == ST_ARMED && s_reg.sync != SYNC_SLAVE &&
      s_reg.src == SRC_THRES && !s_reg.above &&
      ch0_level_in > s_reg.thresh |=> running_out)
      else $error("threshold crossing missed");
   master_drive_a: assert property (@(posedge clk_in) disable iff (rst_in)
      s_reg.sync == SYNC_MASTER |-> link_oe_out)
      else $error("master not driving cable");
   slave_local_a: assert property (@(posedge clk_in) disable iff (rst_in)
      s_reg.sync == SYNC_SLAVE && s_reg.st == ST_ARMED && !s_reg.lt_s
      |=> !running_out)
      else $error("slave started without cable trigger");
   none_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
      s_reg.sync == SYNC_NONE |-> !link_oe_out && !link_out.sync_trig)
      else $error("cable driven in none mode");
   mode_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !wr_ctrl |=> $stable(s_reg.sync))
      else $error("sync mode changed without write");
   slave_run_a: assert property (@(posedge clk_in) disable iff (rst_in)
      running_out && !(wr_cmd && wdata_in[CMD_STOP_BIT]) |=> running_out)
      else $error("run ended without stop");
   stop_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
      s_reg.st == ST_ARMED && s_reg.sync == SYNC_SLAVE && !fire && ce_in &&
      wr_cmd && wdata_in[CMD_STOP_BIT] |=> s_reg.st == ST_STOP)
      else $error("slave stop not delayed");
   one_shot_a: assert property (@(posedge clk_in) disable iff (rst_in)
      running_out && ce_in && wr_cmd && wdata_in[CMD_ARM_BIT] &&
      !wdata_in[CMD_STOP_BIT] |=> running_out)
      else $error("rearm disturbed a run");
   // Threshold clamp, pacing, slave drive, clock-enable, stop-wait and state-hold checks
   clamp_lo_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == OFS_THRESH && wdata_in[6:0] < THRESH_MIN
      |=> s_reg.thresh == THRESH_MIN)
      else $error("threshold not clamped to minimum");
   clamp_hi_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == OFS_THRESH && wdata_in[6:0] > THRESH_MAX
      |=> s_reg.thresh == THRESH_MAX)
      else $error("threshold not clamped to maximum");
   tick_run_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !running_out |-> !sample_tick_out)
      else $error("sample tick outside a run");
   slave_tick_a: assert property (@(posedge clk_in) disable iff (rst_in)
      s_reg.sync == SYNC_SLAVE && running_out && s_reg.lc_s && !s_reg.lc_d
      |-> sample_tick_out)
      else $error("slave missed cable clock edge");
   master_clk_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in |=> s_reg.tick == (link_out.sync_clk != $past(link_out.sync_clk)))
      else $error("cable clock out of step with tick");
   slave_no_drive_a: assert property (@(posedge clk_in) disable iff (rst_in)
      s_reg.sync == SYNC_SLAVE |-> !link_oe_out)
      else $error("slave driving cable");
   ce_freeze_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !ce_in |=> $stable(s_reg))
      else $error("state moved with clock enable low");
   stop_done_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && s_reg.st == ST_STOP && s_reg.wait_cnt <= 40'h0000000001
      |=> s_reg.st == ST_IDLE)
      else $error("slave stop wait did not end");
   armed_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && s_reg.st == ST_ARMED && !fire &&
      !(wr_cmd && wdata_in[CMD_STOP_BIT]) |=> s_reg.st == ST_ARMED)
      else $error("armed state left without event");
   idle_quiet_a: assert property (@(posedge clk_in) disable iff (rst_in)
      s_reg.st == ST_IDLE |-> !running_out && !sample_tick_out)
      else $error("idle block reports running");
endmodule

/* File: verilog/trig_sync_pkg.sv */
// Package: constants and carriers for the output trigger and module sync block
// Assumes a 125 MHz module clock and a host command port of plain strobes
package trig_sync_pkg;
   // Register offsets (word index on the command port)
   localparam logic [3:0] OFS_CTRL      = 4'h0;
   localparam logic [3:0] OFS_THRESH    = 4'h1;
   localparam logic [3:0] OFS_CMD       = 4'h2;
   localparam logic [3:0] OFS_STATUS    = 4'h3;
   localparam logic [3:0] OFS_DIV       = 4'h4;
   // Control fields
   localparam int CTRL_SRC_LSB  = 0;
   localparam int CTRL_SYNC_LSB = 2;
   // Command bits
   localparam int CMD_ARM_BIT   = 0;
   localparam int CMD_STOP_BIT  = 1;
   localparam int CMD_START_BIT = 2;
   // Threshold in 0.1 V steps, range 0.2 V to 9.8 V, hysteresis 0.1 V
   localparam logic [6:0] THRESH_MIN   = 7'h02;
   localparam logic [6:0] THRESH_MAX   = 7'h62;
   localparam logic [6:0] THRESH_RESET = 7'h0A;
   localparam logic [6:0] HYST_STEPS   = 7'h01;
   // Default clock divider from the bus-derived module clock
   localparam logic [15:0] DIV_RESET   = 16'h0001;
   // Slave stop delay while still waiting for a trigger
   localparam int CLK_MHZ        = 125;
   localparam int STOP_WAIT_S    = 20;
   localparam longint STOP_WAIT_CYC =
      longint'(STOP_WAIT_S) * 64'd1000000 * longint'(CLK_MHZ);

   typedef enum logic [1:0] {
      SRC_SOFT  = 2'h0,
      SRC_EXT   = 2'h1,
      SRC_THRES = 2'h2
   } src_t;

   typedef enum logic [1:0] {
      SYNC_NONE   = 2'h0,
      SYNC_MASTER = 2'h1,
      SYNC_SLAVE  = 2'h2
   } sync_t;

   // Gray along IDLE -> ARMED -> RUN -> STOPPING
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_RUN   = 2'b11,
      ST_STOP  = 2'b10
   } state_t;

   typedef struct packed {
      logic       sync_trig;
      logic       sync_clk;
   } sync_link_t;
endpackage
